// ==== pce_pkg.sv ====
// Package: control block layout, codes, CRC helper and word carrier
package pce_pkg;

  // ----------------------------------------
  // Block layout (bit 64 goes out first)
  // ----------------------------------------
  localparam int BLK_W        = 65;
  localparam int PAY_W        = 64;
  localparam int POS_TYPE     = 64;
  localparam int POS_EOP_FLG  = 63;
  localparam int POS_EOP_OFF  = 57;
  localparam int POS_DCRC     = 49;
  localparam int POS_SOP_FLG  = 48;
  localparam int POS_SOP_OFF  = 41;
  localparam int POS_PROTO    = 33;
  localparam int POS_LEN_FLG  = 32;
  localparam int POS_LEN      = 15;
  localparam int POS_PSPEC    = 8;
  localparam int POS_BLOCK_CRC_FIELD     = 0;
  localparam int CRC_COVER    = 57;

  // ----------------------------------------
  // Field codes
  // ----------------------------------------
  localparam logic       TYPE_CTRL   = 1'h1;
  localparam logic       TYPE_DATA   = 1'h0;
  localparam logic [6:0] SOP_DEFER   = 7'h40;
  localparam logic [7:0] PROTO_ETH   = 8'h01;
  localparam logic [7:0] PROTO_IDLE  = 8'h00;
  localparam logic [7:0] PROTO_PAD   = 8'hFF;
  localparam logic [7:0] CRC_INIT    = 8'h00;
  localparam logic [7:0] CRC_POLY    = 8'h07;
  localparam int         BUF_DEPTH   = 2;

  typedef enum logic {
    ST_GAP = 1'b0,
    ST_PKT = 1'b1
  } pce_state_e;

  // ----------------------------------------
  // Word handed to the user side
  // ----------------------------------------
  typedef struct packed {
    logic [63:0] data;
    logic        sop;
    logic [5:0]  sop_pos;
    logic        eop;
    logic [5:0]  eop_pos;
    logic [7:0]  proto;
    logic        len_known;
    logic [16:0] len;
    logic        crc_err;
  } pce_word_s;

  // Serial CRC8 over masked bits, MSB first
  function automatic logic [7:0] pce_crc8(input logic [7:0] crc_in,
                                          input logic [63:0] bits,
                                          input logic [63:0] mask);
    logic [7:0] c;
    logic       fb;
    c = crc_in;
    for (int i = 63; i >= 0; i--) begin
      fb = c[7] ^ bits[i];
      if (mask[i]) begin
        c = {c[6:0], 1'b0} ^ (fb ? CRC_POLY : 8'h00);
      end
    end
    return c;
  endfunction

endpackage

// ==== pce_buf2.sv ====
// Two-entry buffer with registered ready, head word straight from a flop
`timescale 1ns/1ps
`default_nettype none
module pce_buf2 import pce_pkg::*; #(
  parameter int W = 8
) (
  input  wire logic         clk,
  input  wire logic         sys_rst,
  input  wire logic         clk_en,
  input  wire logic         in_valid,
  input  wire logic [W-1:0] in_data,
  output logic              in_ready,
  output logic              out_valid,
  output logic [W-1:0]      out_data,
  input  wire logic         out_ready
);
  logic [W-1:0] tail_r;
  logic [1:0]   cnt_r;
  logic         push;
  logic         pop;

  assign push = in_valid && in_ready;
  assign pop  = out_valid && out_ready;

  // ----------------------------------------
  // Occupancy and flags
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      cnt_r     <= 2'h0;
      in_ready  <= 1'b0;
      out_valid <= 1'b0;
    end else if (clk_en) begin
      cnt_r     <= 2'(cnt_r + {1'b0, push} - {1'b0, pop});
      in_ready  <= 2'(cnt_r + {1'b0, push} - {1'b0, pop}) != 2'(BUF_DEPTH);
      out_valid <= 2'(cnt_r + {1'b0, push} - {1'b0, pop}) != 2'h0;
    end
  end

  // ----------------------------------------
  // Storage
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      out_data <= '0;
      tail_r   <= '0;
    end else if (clk_en) begin
      if (cnt_r == 2'h2 && pop) begin
        out_data <= tail_r;
      end else if (push && (cnt_r == 2'h0 || (cnt_r == 2'h1 && pop))) begin
        out_data <= in_data;
      end
      if (push && cnt_r != 2'h0 && !(cnt_r == 2'h1 && pop)) begin
        tail_r <= in_data;
      end
    end
  end
endmodule
`default_nettype wire

// ==== pce_deframer.sv ====
// Receiving end: parses 65-bit blocks into payload words with packet marks
`timescale 1ns/1ps
`default_nettype none
module pce_deframer import pce_pkg::*; (
  input  wire logic             clk,
  input  wire logic             sys_rst,
  input  wire logic             clk_en,
  input  wire logic             blk_valid,
  input  wire logic [BLK_W-1:0] blk_data,
  output logic                  blk_ready,
  output logic                  word_valid,
  output pce_word_s             word_out,
  input  wire logic             word_ready,
  output logic                  idle_seen,
  output logic                  pad_seen,
  output logic                  ctl_crc_err,
  output logic                  rsv_seen
);
  // ----------------------------------------
  // Field split
  // ----------------------------------------
  logic        take;
  logic        is_ctrl;
  logic        f_eop;
  logic [5:0]  f_eop_off;
  logic [7:0]  f_dcrc;
  logic        f_sop;
  logic [6:0]  f_sop_off;
  logic [7:0]  f_proto;
  logic        f_len_flg;
  logic [16:0] f_len;
  logic [7:0]  f_block_crc_field;
  logic        block_crc_field_ok;
  logic        buf_in_ready;

  assign take      = blk_valid && buf_in_ready;
  assign is_ctrl   = blk_data[POS_TYPE] == TYPE_CTRL;
  assign f_eop     = blk_data[POS_EOP_FLG];
  assign f_eop_off = blk_data[POS_EOP_OFF +: 6];
  assign f_dcrc    = blk_data[POS_DCRC +: 8];
  assign f_sop     = blk_data[POS_SOP_FLG];
  assign f_sop_off = blk_data[POS_SOP_OFF +: 7];
  assign f_proto   = blk_data[POS_PROTO +: 8];
  assign f_len_flg = blk_data[POS_LEN_FLG];
  assign f_len     = blk_data[POS_LEN +: 17];
  assign f_block_crc_field    = blk_data[POS_BLOCK_CRC_FIELD +: 8];
  // Protocol-specific bits not decoded, only covered by the block CRC
  assign block_crc_field_ok   = pce_crc8(CRC_INIT, {blk_data[64:8], 7'h00},
                              {{CRC_COVER{1'b1}}, 7'h00}) == f_block_crc_field;

  // ----------------------------------------
  // Pending marks from the last control block
  // ----------------------------------------
  logic        p_sop_r;
  logic [6:0]  p_sop_off_r;
  logic        p_eop_r;
  logic [5:0]  p_eop_off_r;
  logic [7:0]  p_dcrc_r;
  logic [7:0]  p_proto_r;
  logic        p_len_flg_r;
  logic [16:0] p_len_r;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      p_sop_r     <= 1'b0;
      p_sop_off_r <= 7'h00;
      p_eop_r     <= 1'b0;
      p_eop_off_r <= 6'h00;
      p_dcrc_r    <= 8'h00;
      p_proto_r   <= 8'h00;
      p_len_flg_r <= 1'b0;
      p_len_r     <= 17'h00000;
    end else if (clk_en && take) begin
      if (is_ctrl && block_crc_field_ok) begin
        if (f_sop) begin
          p_sop_r     <= 1'b1;
          p_sop_off_r <= f_sop_off;
          p_proto_r   <= f_proto;
          p_len_flg_r <= f_len_flg;
          p_len_r     <= f_len_flg ? f_len : 17'h00000;
        end
        if (f_eop) begin
          p_eop_r     <= 1'b1;
          p_eop_off_r <= f_eop_off;
          p_dcrc_r    <= f_dcrc;
        end
      end else if (!is_ctrl) begin
        p_eop_r <= 1'b0;
        if (p_sop_r && p_sop_off_r == SOP_DEFER) begin
          p_sop_off_r <= 7'h00;
        end else begin
          p_sop_r <= 1'b0;
        end
      end
    end
  end

  // ----------------------------------------
  // Per-bit packet masks for a data block
  // ----------------------------------------
  pce_state_e  state_r;
  logic [7:0]  crc_acc_r;
  logic        sop_here;
  logic        eop_here;
  logic        short_pkt;
  logic [63:0] mask_old;
  logic [63:0] mask_new;
  logic [7:0]  crc_old;
  logic [7:0]  crc_new;
  logic        in_pkt;

  assign in_pkt    = state_r == ST_PKT;
  assign sop_here  = p_sop_r && p_sop_off_r != SOP_DEFER;
  assign eop_here  = p_eop_r;
  assign short_pkt = eop_here && !in_pkt;

  genvar gi;
  generate
    for (gi = 0; gi < PAY_W; gi++) begin : g_mask
      // Payload bit index gi sits at data bit 63-gi
      assign mask_old[PAY_W-1-gi] = in_pkt && (!eop_here || 6'(gi) <= p_eop_off_r);
      assign mask_new[PAY_W-1-gi] = sop_here && 7'(gi) >= p_sop_off_r
                                    && (!short_pkt || 6'(gi) <= p_eop_off_r);
    end
  endgenerate

  assign crc_old = pce_crc8(crc_acc_r, blk_data[PAY_W-1:0], mask_old);
  assign crc_new = pce_crc8(CRC_INIT, blk_data[PAY_W-1:0], mask_new);

  // ----------------------------------------
  // Packet tracking and running CRC
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state_r   <= ST_GAP;
      crc_acc_r <= CRC_INIT;
    end else if (clk_en && take && !is_ctrl) begin
      crc_acc_r <= sop_here ? crc_new : crc_old;
      case (state_r)
        ST_GAP: begin
          if (sop_here && !short_pkt) begin
            state_r <= ST_PKT;
          end
        end
        ST_PKT: begin
          if (eop_here && !sop_here) begin
            state_r <= ST_GAP;
          end
        end
        default: begin
          state_r <= ST_GAP;
        end
      endcase
    end
  end

  // ----------------------------------------
  // Word build and buffer
  // ----------------------------------------
  pce_word_s wnew;
  logic      push;

  assign push = clk_en && take && !is_ctrl;

  always_comb begin
    wnew           = '0;
    wnew.data      = blk_data[PAY_W-1:0];
    wnew.sop       = sop_here;
    wnew.sop_pos   = p_sop_off_r[5:0];
    wnew.eop       = eop_here;
    wnew.eop_pos   = p_eop_off_r;
    wnew.proto     = sop_here ? p_proto_r : 8'h00;
    wnew.len_known = sop_here && p_len_flg_r;
    wnew.len       = sop_here ? p_len_r : 17'h00000;
    wnew.crc_err   = eop_here && ((in_pkt ? crc_old : crc_new) != p_dcrc_r);
  end

  pce_buf2 #(
    .W ($bits(pce_word_s))
  ) u_buf (
    .clk       (clk),
    .sys_rst   (sys_rst),
    .clk_en    (clk_en),
    .in_valid  (push),
    .in_data   (wnew),
    .in_ready  (buf_in_ready),
    .out_valid (word_valid),
    .out_data  (word_out),
    .out_ready (word_ready)
  );

  assign blk_ready = buf_in_ready;

  // ----------------------------------------
  // Control block event pulses
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      idle_seen   <= 1'b0;
      pad_seen    <= 1'b0;
      ctl_crc_err <= 1'b0;
      rsv_seen    <= 1'b0;
    end else if (clk_en) begin
      idle_seen   <= take && is_ctrl && block_crc_field_ok && !f_sop && !f_eop
                     && f_proto == PROTO_IDLE;
      pad_seen    <= take && is_ctrl && block_crc_field_ok && !f_sop && !f_eop
                     && f_proto == PROTO_PAD;
      ctl_crc_err <= take && is_ctrl && !block_crc_field_ok;
      rsv_seen    <= take && is_ctrl && block_crc_field_ok
                     && ((f_sop && (f_proto != PROTO_ETH || f_sop_off > SOP_DEFER))
                     || (!f_sop && !f_eop && f_proto != PROTO_IDLE
                         && f_proto != PROTO_PAD));
    end
  end
endmodule
`default_nettype wire

// ==== pce_checker.sv ====
// Checker: port properties of the block parser
`timescale 1ns/1ps
`default_nettype none
module pce_checker import pce_pkg::*; (
  input wire logic             clk,
  input wire logic             sys_rst,
  input wire logic             clk_en,
  input wire logic             blk_valid,
  input wire logic [BLK_W-1:0] blk_data,
  input wire logic             blk_ready,
  input wire logic             word_valid,
  input wire pce_word_s        word_out,
  input wire logic             word_ready,
  input wire logic             idle_seen,
  input wire logic             pad_seen,
  input wire logic             ctl_crc_err,
  input wire logic             rsv_seen
);
  logic       take;
  logic       ctl;
  logic [9:0] kind;
  assign take = clk_en && blk_valid && blk_ready;
  assign ctl = take && blk_data[POS_TYPE];
  assign kind = {blk_data[POS_EOP_FLG], blk_data[POS_SOP_FLG], blk_data[40:33]};
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  data_word_a: assert property (
    take && !blk_data[POS_TYPE] && !word_valid
    |=> word_valid && word_out.data == $past(blk_data[63:0]))
    else $error("data word lost");
  ctrl_no_word_a: assert property (
    ctl && !word_valid |=> !word_valid) else $error("control block made a word");
  idle_src_a: assert property (
    idle_seen && $past(clk_en) |-> $past(ctl && kind == {2'b00, PROTO_IDLE}))
    else $error("bad idle");
  pad_src_a: assert property (
    pad_seen && $past(clk_en) |-> $past(ctl && kind == {2'b00, PROTO_PAD})) else $error("bad pad");
  crc_src_a: assert property (
    ctl_crc_err && $past(clk_en) |-> $past(ctl)) else $error("stray crc error");
  rsv_src_a: assert property (
    rsv_seen && $past(clk_en) |-> $past(ctl)) else $error("stray reserved flag");
  word_hold_a: assert property (
    word_valid && !(word_ready && clk_en) |=> word_valid && $stable(word_out))
    else $error("word moved");
  pulse_excl_a: assert property (
    idle_seen |-> !pad_seen && !ctl_crc_err) else $error("two kinds at once");
endmodule
bind pce_deframer pce_checker u_chk (.clk(clk), .sys_rst(sys_rst), .clk_en(clk_en),
  .blk_valid(blk_valid), .blk_data(blk_data), .blk_ready(blk_ready), .word_valid(word_valid),
  .word_out(word_out), .word_ready(word_ready), .idle_seen(idle_seen), .pad_seen(pad_seen),
  .ctl_crc_err(ctl_crc_err), .rsv_seen(rsv_seen));
`default_nettype wire

// ==== pce_sender.sv ====
// Sender model: queued blocks in order, idle blocks whenever the queue is empty
`timescale 1ns/1ps
`default_nettype none
module pce_sender import pce_pkg::*; (
  input  wire logic        clk,
  input  wire logic        sys_rst,
  input  wire logic        clk_en,
  input  wire logic        blk_ready,
  output logic             blk_valid,
  output logic [BLK_W-1:0] blk_data
);
  logic [BLK_W-1:0] q[$];

  function automatic logic [7:0] crc(input logic [7:0] c, input logic [64:0] b, input int hi,
                                     input int lo);
    for (int i = hi; i >= lo; i--) c = {c[6:0], 1'b0} ^ ((c[7] ^ b[i]) ? CRC_POLY : 8'h00);
    return c;
  endfunction

  task automatic put_ctrl(input logic e, input logic [5:0] eo, input logic [7:0] dc,
                          input logic s, input logic [6:0] so, input logic [7:0] pr,
                          input logic lf, input logic [16:0] ln, input logic bad);
    logic [BLK_W-1:0] b;
    b = {TYPE_CTRL, e, eo, dc, s, so, pr, lf, ln, 7'h00, 8'h00};
    b[7:0] = crc(CRC_INIT, b, 64, 8) ^ {7'h00, bad};
    q.push_back(b);
  endtask

  task automatic put_data(input logic [63:0] d);
    q.push_back({TYPE_DATA, d});
  endtask

  initial begin
    blk_valid = 1'b0;
    blk_data = '0;
    forever begin
      @(posedge clk);
      if (sys_rst) begin
        #1 blk_valid = 1'b0;
        blk_data = ~blk_data;
      end else if (!blk_valid || (blk_ready && clk_en)) begin
        #1 blk_valid = 1'b1;
        if (q.size() > 0) blk_data = q.pop_front();
        else blk_data = {TYPE_CTRL, 56'h0, crc(CRC_INIT, {TYPE_CTRL, 64'h0}, 64, 8)};
      end
    end
  end
endmodule
`default_nettype wire

// ==== tb_top.sv ====
// Testbench: block parser fed by the sender model
`timescale 1ns/1ps
`default_nettype none
module tb_top import pce_pkg::*;;
  logic             clk, sys_rst, clk_en, word_ready, blk_valid, blk_ready, word_valid;
  logic             idle_seen, pad_seen, ctl_crc_err, rsv_seen;
  logic [BLK_W-1:0] blk_data;
  pce_word_s        word_out;
  pce_word_s        got[$];
  int               fail_count, tests_run, n_pad, n_cerr, n_rsv, n_idle;

  pce_sender u_snd (.clk(clk), .sys_rst(sys_rst), .clk_en(clk_en), .blk_ready(blk_ready),
    .blk_valid(blk_valid), .blk_data(blk_data));
  pce_deframer dut (.clk(clk), .sys_rst(sys_rst), .clk_en(clk_en), .blk_valid(blk_valid),
    .blk_data(blk_data), .blk_ready(blk_ready), .word_valid(word_valid), .word_out(word_out),
    .word_ready(word_ready), .idle_seen(idle_seen), .pad_seen(pad_seen),
    .ctl_crc_err(ctl_crc_err), .rsv_seen(rsv_seen));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  always @(posedge clk) begin
    if (!sys_rst && clk_en) begin
      if (word_valid && word_ready) got.push_back(word_out);
      n_pad += pad_seen;
      n_cerr += ctl_crc_err;
      n_rsv += rsv_seen;
      n_idle += idle_seen;
    end
  end

  function automatic logic [14:0] mark(input pce_word_s w);
    return {w.sop, w.sop ? w.sop_pos : 6'h00, w.eop, w.eop ? {w.eop_pos, w.crc_err} : 7'h00};
  endfunction

  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    tests_run++;
    if (seen !== exp) begin
      fail_count++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic wait_words(input int n);
    for (int i = 0; i < 300 && got.size() < n; i++) @(posedge clk);
    chk(got.size() >= n, 1);
  endtask

  task automatic t_pkt;
    logic [63:0] d[4];
    logic [14:0] em[4];
    logic [7:0]  c1;
    logic [7:0]  c2;
    d = '{64'hA5A5_0F0F_1234_5678, 64'h0123_89AB_CDEF_4567, 64'hF0F0, 64'h8001};
    em = '{15'h4500, 15'h00FE, 15'h4000, 15'h0081};
    c1 = u_snd.crc(u_snd.crc(CRC_INIT, {1'b0, d[0]}, 58, 0), {1'b0, d[1]}, 63, 0);
    c2 = u_snd.crc(u_snd.crc(CRC_INIT, {1'b0, d[2]}, 63, 0), {1'b0, d[3]}, 63, 63);
    got.delete();
    u_snd.put_ctrl(0, 0, 0, 1, 7'h05, PROTO_ETH, 1, 17'h1FFFF, 0);
    u_snd.put_data(d[0]);
    u_snd.put_ctrl(1, 6'h3F, c1, 1, SOP_DEFER, PROTO_ETH, 0, 0, 0);
    u_snd.put_data(d[1]);
    u_snd.put_data(d[2]);
    u_snd.put_ctrl(1, 0, ~c2, 0, 0, 0, 0, 0, 0);
    u_snd.put_data(d[3]);
    wait_words(4);
    chk({got[0].proto, got[0].len_known, got[0].len}, {PROTO_ETH, 1'b1, 17'h1FFFF});
    chk({got[2].proto, got[2].len_known}, {PROTO_ETH, 1'b0});
    for (int i = 0; i < 4; i++) begin
      chk(mark(got[i]), em[i]);
      chk(got[i].data, d[i]);
    end
  endtask

  task automatic t_special;
    got.delete();
    n_pad = 0;
    n_cerr = 0;
    n_rsv = 0;
    n_idle = 0;
    u_snd.put_ctrl(0, 0, 0, 0, 0, PROTO_PAD, 0, 0, 0);
    u_snd.put_ctrl(0, 0, 0, 1, 0, PROTO_ETH, 0, 0, 1);
    u_snd.put_data(64'h1);
    u_snd.put_ctrl(0, 0, 0, 1, 0, 8'h02, 0, 0, 0);
    u_snd.put_data(64'h2);
    wait_words(2);
    repeat (2) @(posedge clk);
    chk(n_pad, 1);
    chk(n_cerr, 1);
    chk(n_rsv, 1);
    chk(n_idle != 0, 1);
    chk(mark(got[0]), 15'h0000);
    chk(mark(got[1]), 15'h4000);
  endtask

  task automatic t_stall;
    #1 word_ready = 1'b0;
    got.delete();
    for (int i = 0; i < 4; i++) u_snd.put_data(64'hC0DE_0000 + i);
    repeat (20) @(posedge clk);
    #1 clk_en = 1'b0;
    word_ready = 1'b1;
    chk(blk_ready, 0);
    repeat (5) @(posedge clk);
    chk(got.size(), 0);
    #1 clk_en = 1'b1;
    wait_words(4);
    for (int i = 0; i < 4; i++) chk(got[i].data, 64'hC0DE_0000 + i);
  endtask

  task automatic summarize;
    $display("checks=%0d mismatches=%0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  initial begin
    sys_rst = 1'b1;
    clk_en = 1'b1;
    word_ready = 1'b1;
    repeat (8) @(posedge clk);
    #1 sys_rst = 1'b0;
    t_pkt();
    t_special();
    t_stall();
    summarize();
  end

  initial begin
    #100000;
    fail_count++;
    summarize();
  end
endmodule
`default_nettype wire
